//--- hw/wbc_regs.sv
// Function
// (RQ1) Restart clears failure-output enable, outputs off
// (RQ2) Soft reset keeps aux voltage, load-share bits
// (RQ3) Host writes watchdog byte with even parity
// (RQ4) Watchdog bit 6: stop-mode disable, low half
// (RQ5) Watchdog bit 5: time-out or window type
// (RQ6) Watchdog bit 4: start after bus wake
// (RQ7) Period codes 0..5 map 10..500 ms
// (RQ8) Reserved bits unwritable, read as zero
// (RQ9) Watchdog reset 0x14; restart keeps 7,5,4
// (RQ10) Mode field: off, wake, rx-only, normal
// (RQ11) Selective-wake bit changed only by host
// (RQ12) Restart clears transceiver upper five bits
// (RQ13) Sleep, no system error: normal becomes wake
// (RQ14) Rx-only: wake on sleep, kept on stop
// (RQ15) Off and wake modes kept on sleep/stop
// (RQ16) Host selects rx-only before stop entry
// (RQ17) Fail-safe forces wake-capable, wake sources on
// (RQ18) Peak bit selects low or high threshold
// (RQ19) Peak bit writable only in init/normal
// (RQ20) Ignored peak write raises no failure
// (RQ21) Period code 6 treated like reserved 7
`timescale 1ns/1ps
`default_nettype none

module wbc_regs
  import wbc_pkg::*;
(
  // System clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_rst_n,
  // Serial link, link clock domain
  input  wire logic          i_spi_sclk,
  input  wire logic          i_spi_csn,
  input  wire logic          i_spi_sdi,
  output logic               o_spi_sdo,
  // Mode events and levels from the state machine
  input  wire logic          i_soft_reset,
  input  wire logic          i_enter_restart,
  input  wire logic          i_enter_sleep,
  input  wire logic          i_enter_stop,
  input  wire logic          i_enter_failsafe,
  input  wire logic          i_mode_init_normal,
  input  wire logic          i_system_error_setting,
  // Register contents and decoded settings
  output logic [7:0]         o_hardware_control,
  output logic [7:0]         o_external_wake_control,
  output logic               o_failure_outputs,
  output logic               o_aux_reg_voltage_select,
  output logic               o_aux_reg_load_sharing,
  output logic               o_peak_current_threshold,
  output wbc_wdog_type       o_wdog,
  output wbc_xcvr_type       o_xcvr,
  output logic               o_spi_fail
);

  // Period decode; codes 6 and 7 give no period
  function automatic logic [10:0] wd_period(input logic [2:0] code);
    logic [10:0] r;
    r = '0;
    unique case (code)
      3'h0: r = {WBC_WD_MS0, 1'b1};
      3'h1: r = {WBC_WD_MS1, 1'b1};
      3'h2: r = {WBC_WD_MS2, 1'b1};
      3'h3: r = {WBC_WD_MS3, 1'b1};
      3'h4: r = {WBC_WD_MS4, 1'b1};
      3'h5: r = {WBC_WD_MS5, 1'b1};
      3'h6: r = '0;  // see (RQ21)
      3'h7: r = '0;  // see (RQ7)
    endcase
    return r;
  endfunction

  // Link domain state
  logic [3:0]    cnt_q;    // Bits taken in this frame
  logic [14:0]   shift_q;  // Bits gathered so far
  wbc_frame_type frame_q;  // Last complete frame
  logic          tgl_q;    // Flips once per frame
  logic          sdo_q;    // Answer bit on the wire

  // System domain state
  logic          tgl_s1_q, tgl_s2_q, tgl_s3_q;  // Frame toggle sync
  logic [15:0]   rsp_q;                         // Answer word for next frame
  logic [7:0]    hw_q, hw_d;                    // hardware_control
  logic [7:0]    wd_q, wd_d;                    // watchdog_config
  logic [7:0]    bus_q, bus_d;                  // transceiver_mode_config
  logic [7:0]    peak_q, peak_d;                // peak_threshold_config
  logic [7:0]    ext_q, ext_d;                  // external_wake_control
  wbc_wdog_type  wdog_q;                        // Decoded watchdog
  wbc_xcvr_type  xcvr_q;                        // Decoded transceiver
  logic          fail_q;                        // Unmapped access pulse

  // Frame gathering; chip select high clears the bit count
  always_ff @(posedge i_spi_sclk or posedge i_spi_csn) begin
    if (i_spi_csn) begin
      cnt_q   <= '0;
      shift_q <= '0;
    end else begin
      cnt_q   <= cnt_q + 4'h1;
      shift_q <= {i_spi_sdi, shift_q[14:1]};
    end
  end

  // Capture of the sixteenth bit and frame event toggle
  always_ff @(posedge i_spi_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_q <= '0;
      tgl_q   <= 1'b0;
    end else if (!i_spi_csn && cnt_q == WBC_CNT_LAST) begin
      frame_q <= {i_spi_sdi, shift_q};
      tgl_q   <= ~tgl_q;
    end
  end

  // Answer bits change on the falling edge; bit 0 is always zero
  always_ff @(negedge i_spi_sclk or posedge i_spi_csn) begin
    if (i_spi_csn) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= rsp_q[cnt_q];
    end
  end

  // Frame event brought into the system domain
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  // Frame decode; frame_q is stable while its event is seen
  wire       frm_evt  = tgl_s2_q ^ tgl_s3_q;
  wire       frm_wr   = frm_evt & frame_q.wr;
  wire [7:0] wdata    = frame_q.data;
  wire       hit_hw   = frame_q.addr == WBC_ADDR_HW;
  wire       hit_wd   = frame_q.addr == WBC_ADDR_WD;
  wire       hit_bus  = frame_q.addr == WBC_ADDR_BUS;
  wire       hit_peak = frame_q.addr == WBC_ADDR_PEAK;
  wire       hit_ext  = frame_q.addr == WBC_ADDR_EXT;
  wire       hit_any  = hit_hw | hit_wd | hit_bus | hit_peak | hit_ext;
  wire       wr_hw    = frm_wr & hit_hw;
  wire       wr_wd    = frm_wr & hit_wd;
  wire       wr_bus   = frm_wr & hit_bus;
  wire       wr_peak  = frm_wr & hit_peak & i_mode_init_normal;  // see (RQ19)
  wire       wr_ext   = frm_wr & hit_ext;
  wire [1:0] bus_mode = bus_q[1:0];

  // Read selection shows the value held before this frame's write
  wire [7:0] rd_data = hit_hw   ? hw_q   :
                       hit_wd   ? wd_q   :
                       hit_bus  ? bus_q  :
                       hit_peak ? peak_q :
                       hit_ext  ? ext_q  : 8'h00;

  // Sleep rewrite of the two low mode bits
  wire [1:0] sleep_mode = ((bus_mode == WBC_XM_NORM) && !i_system_error_setting) ? WBC_XM_WAKE :  // see (RQ13)
                          (bus_mode == WBC_XM_RXO) ? WBC_XM_WAKE :                             // see (RQ14)
                          bus_mode;                                                            // see (RQ15)

  // hardware_control next value
  always_comb begin
    hw_d = hw_q;
    if (wr_hw) begin
      hw_d = wdata & WBC_HW_WMASK;                // see (RQ8)
    end
    if (i_soft_reset) begin
      hw_d = hw_q & WBC_HW_SOFT_KEEP;             // see (RQ2)
    end
    if (i_enter_restart) begin
      hw_d = hw_q & WBC_HW_RESTART_KEEP;          // see (RQ1)
    end
  end

  // watchdog_config next value
  always_comb begin
    wd_d = wd_q;
    if (wr_wd) begin
      wd_d = wdata & WBC_WD_WMASK;                // see (RQ8)
    end
    if (i_soft_reset) begin
      wd_d = WBC_WD_RST;                          // see (RQ9)
    end
    if (i_enter_restart) begin
      wd_d = (wd_q & WBC_WD_RESTART_KEEP) | WBC_WD_RESTART_SET;  // see (RQ9)
    end
  end

  // transceiver_mode_config next value; mode events win over writes
  always_comb begin
    bus_d = bus_q;
    if (wr_bus) begin
      bus_d = wdata & WBC_BUS_WMASK;              // see (RQ8)
    end
    if (i_enter_sleep) begin
      bus_d = {5'h00, bus_q[WBC_BUS_SWK], sleep_mode};  // see (RQ11)
    end
    if (i_soft_reset) begin
      bus_d = WBC_BUS_RST;
    end
    if (i_enter_restart) begin
      bus_d = {5'h00, bus_q[2:0]};                // see (RQ12)
    end
    if (i_enter_failsafe) begin
      bus_d = {5'h00, bus_q[WBC_BUS_SWK], WBC_XM_WAKE};  // see (RQ17)
    end
  end

  // peak_threshold_config next value
  always_comb begin
    peak_d = peak_q;
    if (wr_peak) begin
      peak_d = wdata & WBC_PEAK_WMASK;            // see (RQ18)
    end
    if (i_soft_reset) begin
      peak_d = WBC_PEAK_RST;
    end
  end

  // external_wake_control next value
  always_comb begin
    ext_d = ext_q;
    if (wr_ext) begin
      ext_d = wdata & WBC_EXT_WMASK;
    end
    if (i_soft_reset) begin
      ext_d = WBC_EXT_RST;
    end
    if (i_enter_failsafe) begin
      ext_d = (ext_q & WBC_EXT_FS_KEEP) | WBC_EXT_FS_SET;  // see (RQ17)
    end
  end

  // Register storage
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hw_q   <= WBC_HW_POR;                       // see (RQ2)
      wd_q   <= WBC_WD_RST;
      bus_q  <= WBC_BUS_RST;
      peak_q <= WBC_PEAK_RST;
      ext_q  <= WBC_EXT_RST;
    end else begin
      hw_q   <= hw_d;
      wd_q   <= wd_d;
      bus_q  <= bus_d;
      peak_q <= peak_d;
      ext_q  <= ext_d;
    end
  end

  // Answer word and failure pulse; ignored peak writes are not failures
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_q  <= '0;
      fail_q <= 1'b0;
    end else begin
      fail_q <= frm_evt & !hit_any;               // see (RQ20)
      if (frm_evt) begin
        rsp_q <= {rd_data, 8'h00};
      end
    end
  end

  // Decoded settings
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdog_q <= '0;
      xcvr_q <= '0;
    end else begin
      wdog_q.stop_disable_lo   <= wd_q[WBC_WD_STM];       // see (RQ4)
      wdog_q.window_select     <= wd_q[WBC_WDOG_WINDOW_SELECT];       // see (RQ5)
      wdog_q.start_on_bus_wake <= wd_q[WBC_WD_BUSWK];     // see (RQ6)
      {wdog_q.period_ms, wdog_q.period_valid} <= wd_period(wd_q[2:0]);  // see (RQ7)
      wdog_q.checksum_ok       <= ~^wd_q;                 // see (RQ3)
      xcvr_q.mode              <= bus_mode;               // see (RQ10)
      xcvr_q.selective_wake    <= bus_q[WBC_BUS_SWK];     // see (RQ10)
    end
  end

  // Outputs
  assign o_spi_sdo                = sdo_q;
  assign o_hardware_control       = hw_q;
  assign o_external_wake_control  = ext_q;
  assign o_failure_outputs        = hw_q[WBC_HW_FO];      // see (RQ1)
  assign o_aux_reg_voltage_select = hw_q[WBC_HW_AUX_V];
  assign o_aux_reg_load_sharing   = hw_q[WBC_HW_AUX_LS];
  assign o_peak_current_threshold = peak_q[WBC_PEAK_BIT];
  assign o_wdog                   = wdog_q;
  assign o_xcvr                   = xcvr_q;
  assign o_spi_fail               = fail_q;

  // Checks in the system domain
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // Ignored write while outside init/normal
  sequence s_peak_try_stop;
    frm_wr && hit_peak && !i_mode_init_normal && !i_soft_reset;
  endsequence

  // Quiet cycle with no soft reset, restart or fail-safe entry
  sequence s_quiet;
    !i_soft_reset && !i_enter_restart && !i_enter_failsafe;
  endsequence

  chk_restart_fo_off: assert property (i_enter_restart |=> !o_failure_outputs)  // see (RQ1)
    else $error("failure outputs left on after restart");
  chk_soft_keep_aux: assert property (i_soft_reset && !i_enter_restart |=>  // see (RQ2)
    o_aux_reg_voltage_select == $past(hw_q[WBC_HW_AUX_V]) &&
    o_aux_reg_load_sharing == $past(hw_q[WBC_HW_AUX_LS]) && !o_failure_outputs)
    else $error("soft reset disturbed aux bits");
  chk_wd_soft_value: assert property (i_soft_reset && !i_enter_restart |=> wd_q == WBC_WD_RST)  // see (RQ9)
    else $error("watchdog value wrong after soft reset");
  chk_wd_restart_mix: assert property (i_enter_restart |=>  // see (RQ9)
    wd_q[2:0] == WBC_WD_RESTART_SET[2:0] && !wd_q[WBC_WD_STM] && !wd_q[3] &&
    wd_q[WBC_WD_CHK] == $past(wd_q[WBC_WD_CHK]) && wd_q[WBC_WDOG_WINDOW_SELECT] == $past(wd_q[WBC_WDOG_WINDOW_SELECT]) &&
    wd_q[WBC_WD_BUSWK] == $past(wd_q[WBC_WD_BUSWK]))
    else $error("watchdog value wrong after restart");
  chk_reserved_zero: assert property (!wd_q[3] && bus_q[7:3] == 5'h00 &&  // see (RQ8)
    (peak_q & ~WBC_PEAK_WMASK) == 8'h00 && !hw_q[2] && (ext_q & ~WBC_EXT_WMASK) == 8'h00)
    else $error("reserved bit set");
  chk_sleep_to_wake: assert property ((i_enter_sleep && bus_mode == WBC_XM_NORM) and s_quiet  // see (RQ13)
    and !i_system_error_setting |=> bus_mode == WBC_XM_WAKE ##1 o_xcvr.mode == WBC_XM_WAKE)
    else $error("normal mode not turned to wake on sleep");
  chk_stop_keeps_mode: assert property ((i_enter_stop && !i_enter_sleep && !wr_bus) and s_quiet |=>  // see (RQ14)
    $stable(bus_q))
    else $error("mode changed on stop entry");
  chk_swk_host_only: assert property (!wr_bus && !i_soft_reset |=> $stable(bus_q[WBC_BUS_SWK]))  // see (RQ11)
    else $error("selective wake bit changed by hardware");
  chk_peak_ignored: assert property (s_peak_try_stop |=> $stable(peak_q) && !o_spi_fail)  // see (RQ20)
    else $error("peak write in stop took effect or flagged");
  chk_failsafe_wake: assert property (i_enter_failsafe |=> bus_mode == WBC_XM_WAKE &&  // see (RQ17)
    ext_q[2:0] == WBC_EXT_FS_SET[2:0] && bus_q[7:3] == 5'h00)
    else $error("fail-safe wake values not forced");
  chk_period_invalid: assert property (wd_q[2:1] == 2'h3 |=> !o_wdog.period_valid)  // see (RQ21)
    else $error("reserved period code taken as valid");

endmodule // wbc_regs

`default_nettype wire

//--- hw/wbc_pkg.sv
package wbc_pkg;

  // Register indexes on the serial link
  localparam logic [6:0] WBC_ADDR_HW   = 7'h02;  // hardware_control
  localparam logic [6:0] WBC_ADDR_WD   = 7'h03;  // watchdog_config
  localparam logic [6:0] WBC_ADDR_BUS  = 7'h04;  // transceiver_mode_config
  localparam logic [6:0] WBC_ADDR_PEAK = 7'h05;  // peak_threshold_config
  localparam logic [6:0] WBC_ADDR_EXT  = 7'h07;  // external_wake_control

  // Reset values
  localparam logic [7:0] WBC_HW_POR   = 8'h00;
  localparam logic [7:0] WBC_WD_RST   = 8'h14;
  localparam logic [7:0] WBC_BUS_RST  = 8'h00;
  localparam logic [7:0] WBC_PEAK_RST = 8'h00;
  localparam logic [7:0] WBC_EXT_RST  = 8'h07;

  // Writable bits; reserved bits stay zero
  localparam logic [7:0] WBC_HW_WMASK   = 8'hfb;
  localparam logic [7:0] WBC_WD_WMASK   = 8'hf7;
  localparam logic [7:0] WBC_BUS_WMASK  = 8'h07;
  localparam logic [7:0] WBC_PEAK_WMASK = 8'h20;
  localparam logic [7:0] WBC_EXT_WMASK  = 8'ha7;

  // Bits kept or set on soft reset, restart and fail-safe entry
  localparam logic [7:0] WBC_HW_SOFT_KEEP    = 8'h88;
  localparam logic [7:0] WBC_HW_RESTART_KEEP = 8'hd9;
  localparam logic [7:0] WBC_WD_RESTART_KEEP = 8'hb0;
  localparam logic [7:0] WBC_WD_RESTART_SET  = 8'h04;
  localparam logic [7:0] WBC_EXT_FS_KEEP     = 8'ha0;
  localparam logic [7:0] WBC_EXT_FS_SET      = 8'h07;

  // Field positions
  localparam int WBC_HW_FO     = 5;
  localparam int WBC_HW_AUX_V  = 7;
  localparam int WBC_HW_AUX_LS = 3;
  localparam int WBC_WD_CHK    = 7;
  localparam int WBC_WD_STM    = 6;
  localparam int WBC_WDOG_WINDOW_SELECT    = 5;
  localparam int WBC_WD_BUSWK  = 4;
  localparam int WBC_BUS_SWK   = 2;
  localparam int WBC_PEAK_BIT  = 5;

  // Transceiver mode codes (low two bits)
  localparam logic [1:0] WBC_XM_OFF  = 2'h0;
  localparam logic [1:0] WBC_XM_WAKE = 2'h1;
  localparam logic [1:0] WBC_XM_RXO  = 2'h2;
  localparam logic [1:0] WBC_XM_NORM = 2'h3;

  // Watchdog periods in milliseconds
  localparam logic [9:0] WBC_WD_MS0 = 10'd10;
  localparam logic [9:0] WBC_WD_MS1 = 10'd20;
  localparam logic [9:0] WBC_WD_MS2 = 10'd50;
  localparam logic [9:0] WBC_WD_MS3 = 10'd100;
  localparam logic [9:0] WBC_WD_MS4 = 10'd200;
  localparam logic [9:0] WBC_WD_MS5 = 10'd500;

  // Frame shape
  localparam logic [3:0] WBC_CNT_LAST = 4'hf;

  // Serial frame, first bit on the wire is bit 0
  typedef struct packed {
    logic [7:0] data;
    logic       wr;
    logic [6:0] addr;
  } wbc_frame_type;

  // Decoded watchdog settings
  typedef struct packed {
    logic       stop_disable_lo;
    logic       window_select;
    logic       start_on_bus_wake;
    logic [9:0] period_ms;
    logic       period_valid;
    logic       checksum_ok;
  } wbc_wdog_type;

  // Decoded transceiver mode
  typedef struct packed {
    logic [1:0] mode;
    logic       selective_wake;
  } wbc_xcvr_type;

endpackage

//--- tb/wbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module wbc_host_model
  import wbc_pkg::*;
(
  // Serial link toward the device
  output logic      o_spi_sclk,
  output logic      o_spi_csn,
  output logic      o_spi_sdi,
  // Answer from the device
  input  wire logic i_spi_sdo
);
  // Idle link: clock parked low, device deselected
  initial begin
    o_spi_sclk = 1'b0;
    o_spi_csn  = 1'b1;
    o_spi_sdi  = 1'b0;
  end

  // One 16-bit frame, bit 0 first; answer bit taken just before each rising edge
  task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] data,
                      output logic [15:0] rsp);
    wbc_frame_type f;
    f = '{data: data, wr: wr, addr: addr};
    // Odd offset keeps the link clock unrelated to the system clock
    #1.7 o_spi_csn = 1'b0;
    for (int k = 0; k < 16; k++) begin
      o_spi_sdi = f[k];
      #6 rsp[k] = i_spi_sdo;
      o_spi_sclk = 1'b1;
      #6 o_spi_sclk = 1'b0;
    end
    #6 o_spi_csn = 1'b1;
    // Deselected data line no longer shows the last bit
    o_spi_sdi = ~o_spi_sdi;
    // Gap lets the frame land in the system domain before the next one
    #60;
  endtask
endmodule // wbc_host_model

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

// Compare one value and count it
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected %0t: %s got %h exp %h", $time, msg, got, exp); end end

module testbench
  import wbc_pkg::*;
;
  // Clock, reset and mode events {failsafe, restart, sleep, stop, soft}
  logic              i_mclk;
  logic              i_rst_n;
  logic [4:0]        ev;
  logic              init_normal;
  logic              sys_err;
  // Serial link
  wire logic         sclk;
  wire logic         csn;
  wire logic         sdi;
  wire logic         sdo;
  // Design outputs
  logic [7:0]        hw_ctl;
  logic [7:0]        ext_ctl;
  logic              fo;
  logic              aux_v;
  logic              aux_ls;
  logic              peak;
  logic              spi_fail;
  wbc_wdog_type      wdog;
  wbc_xcvr_type      xcvr;
  // Bench state
  int                fails;
  int                checked;
  int                nfail;
  int                n0;
  logic [15:0]       rsp;
  logic [6:0]        lo;
  logic [2:0]        m;
  logic [2:0]        x;
  logic              s;
  logic              sl;
  logic [9:0]        ms [8] = '{10'd10, 10'd20, 10'd50, 10'd100, 10'd200, 10'd500, 10'd0, 10'd0};

  wbc_regs i_wbc_regs (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_spi_sclk(sclk), .i_spi_csn(csn), .i_spi_sdi(sdi), .o_spi_sdo(sdo),
    .i_soft_reset(ev[0]), .i_enter_stop(ev[1]), .i_enter_sleep(ev[2]),
    .i_enter_restart(ev[3]), .i_enter_failsafe(ev[4]),
    .i_mode_init_normal(init_normal), .i_system_error_setting(sys_err),
    .o_hardware_control(hw_ctl), .o_external_wake_control(ext_ctl),
    .o_failure_outputs(fo), .o_aux_reg_voltage_select(aux_v),
    .o_aux_reg_load_sharing(aux_ls), .o_peak_current_threshold(peak),
    .o_wdog(wdog), .o_xcvr(xcvr), .o_spi_fail(spi_fail)
  );

  wbc_host_model i_wbc_host_model (
    .o_spi_sclk(sclk), .o_spi_csn(csn), .o_spi_sdi(sdi), .i_spi_sdo(sdo)
  );

  // System clock, 200 MHz
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // Count failure pulses of the link, sampled where settled; unknown counts too
  always @(negedge i_mclk) begin
    if (spi_fail !== 1'b0) nfail++;
  end

  // Verdict and end of run
  task automatic test_done();
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Register write
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_wbc_host_model.xfer(a, 1'b1, d, rsp);
  endtask

  // Register read: answer arrives in the following frame
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    i_wbc_host_model.xfer(a, 1'b0, 8'h00, rsp);
    i_wbc_host_model.xfer(a, 1'b0, 8'h00, rsp);
    `CHK(rsp, {exp, 8'h00}, "read")
  endtask

  // One-cycle mode event, driven off the sampling edge
  task automatic pulse(input int i);
    @(negedge i_mclk) ev[i] = 1'b1;
    @(negedge i_mclk) ev = '0;
    repeat (3) @(negedge i_mclk);
  endtask

  // Hang guard
  initial begin
    repeat (40000) @(posedge i_mclk);
    fails++;
    test_done();
  end

  // Main sequence
  initial begin
    i_rst_n = 1'b0;
    ev = '0;
    init_normal = 1'b1;
    sys_err = 1'b0;
    fails = 0;
    checked = 0;
    nfail = 0;
    repeat (16) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_mclk);
    // Power-on values
    rd(WBC_ADDR_HW, 8'h00);
    rd(WBC_ADDR_WD, 8'h14);
    rd(WBC_ADDR_BUS, 8'h00);
    rd(WBC_ADDR_PEAK, 8'h00);
    rd(WBC_ADDR_EXT, 8'h07);
    `CHK(wdog.period_ms, 10'd200, "reset period")
    // Reserved bits stay zero
    wr(WBC_ADDR_WD, 8'hff);
    rd(WBC_ADDR_WD, 8'hf7);
    wr(WBC_ADDR_BUS, 8'hff);
    rd(WBC_ADDR_BUS, 8'h07);
    wr(WBC_ADDR_PEAK, 8'hff);
    rd(WBC_ADDR_PEAK, 8'h20);
    `CHK(peak, 1'b1, "peak high")
    // Peak bit frozen outside init and normal, silently
    @(negedge i_mclk) init_normal = 1'b0;
    pulse(1);
    n0 = nfail;
    wr(WBC_ADDR_PEAK, 8'h00);
    `CHK(nfail, n0, "ignored write flagged")
    rd(WBC_ADDR_PEAK, 8'h20);
    n0 = nfail;
    wr(7'h10, 8'h5a);
    `CHK(nfail, n0 + 1, "unmapped write")
    rd(7'h10, 8'h00);
    @(negedge i_mclk) init_normal = 1'b1;
    wr(WBC_ADDR_PEAK, 8'h00);
    `CHK(peak, 1'b0, "peak low")
    // Every period code, control bits mirroring the code
    for (int c = 0; c < 8; c++) begin
      lo = {c[2:0], 1'b0, c[2:0]};
      wr(WBC_ADDR_WD, {^lo, lo});
      `CHK(wdog.period_ms, ms[c], "period")
      `CHK(wdog.period_valid, c < 6, "period valid")
      `CHK({wdog.stop_disable_lo, wdog.window_select, wdog.start_on_bus_wake}, c[2:0], "wd bits")
      `CHK(wdog.checksum_ok, 1'b1, "parity")
    end
    // Transceiver modes across sleep and stop, both error settings
    for (int i = 0; i < 32; i++) begin
      m = i[2:0];
      s = i[3];
      sl = i[4];
      @(negedge i_mclk) sys_err = s;
      wr(WBC_ADDR_BUS, {5'h00, m});
      pulse(sl ? 2 : 1);
      x = m;
      if (sl && (m[1:0] == 2'h2 || (m[1:0] == 2'h3 && !s))) x[1:0] = 2'h1;
      rd(WBC_ADDR_BUS, {5'h00, x});
      `CHK(xcvr, {x[1:0], x[2]}, "xcvr decode")
    end
    // Restart
    wr(WBC_ADDR_HW, 8'hfb);
    wr(WBC_ADDR_WD, 8'hff);
    wr(WBC_ADDR_BUS, 8'hff);
    `CHK(fo, 1'b1, "outputs on")
    `CHK(wdog.checksum_ok, 1'b0, "odd parity")
    pulse(3);
    `CHK(fo, 1'b0, "outputs off")
    rd(WBC_ADDR_HW, 8'hd9);
    rd(WBC_ADDR_WD, 8'hb4);
    rd(WBC_ADDR_BUS, 8'h07);
    // Soft reset
    wr(WBC_ADDR_HW, 8'hfb);
    pulse(0);
    rd(WBC_ADDR_HW, 8'h88);
    `CHK({aux_v, aux_ls}, 2'h3, "aux kept")
    rd(WBC_ADDR_WD, 8'h14);
    // Fail-safe entry
    wr(WBC_ADDR_BUS, 8'h02);
    wr(WBC_ADDR_EXT, 8'ha0);
    pulse(4);
    rd(WBC_ADDR_BUS, 8'h01);
    rd(WBC_ADDR_EXT, 8'ha7);
    `CHK(ext_ctl, 8'ha7, "ext out")
    // Power-on reset in mid-run
    wr(WBC_ADDR_HW, 8'h88);
    @(negedge i_mclk) i_rst_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_mclk);
    rd(WBC_ADDR_HW, 8'h00);
    `CHK(hw_ctl, 8'h00, "hw out")
    test_done();
  end
endmodule // testbench

`default_nettype wire
